// ### design/pes_pkg.sv
// Constants, field layout and carriers for the performance event selector.
// Assumes one core clock and a register port driven by the core.
//
// Functional notes
// [R1] Event class code in selection bits 31:25; retired branch is 06H.
// [R2] Sub-event mask in selection bits 24:9; mask bit n is bit 9+n.
// [R3] Mask bits 0-3: not-taken pred/mispred, then taken pred/mispred.
// [R4] Software writes zero to mask bits undefined for the chosen class.
// [R5] Config bits 15:13 hold selector number, not address; branch uses 05H.
// [R6] Selector a feeds counters 12,13,16; selector b feeds 14,15,17.
// [R7] Retired branch has no precise sampling and needs no tagging registers.
// [R8] Basic counting runs without limit, wrapping to zero past maximum.
// [R9] Software writes class, mask and privilege flags in one write.
// [R10] Software writes config source select after the selection register.
// [R11] Config fields take one write or several independent writes.
// [R12] Config bit 12 enables counting; cleared by reset.
// [R13] Class and mask match first, then privilege flags qualify the event.
// [R14] Count on class match and enabled sub-event; zero mask counts none.
package pes_pkg;

   // ****************************************************************
   // Register indices
   // ****************************************************************
   localparam logic [7:0]  IDX_SEL_A    = 8'h10;
   localparam logic [7:0]  IDX_SEL_B    = 8'h11;
   localparam logic [7:0]  IDX_CFG0     = 8'h20;
   localparam logic [7:0]  IDX_CNT_LO0  = 8'h30;
   localparam logic [7:0]  IDX_CNT_HI0  = 8'h40;
   localparam int          NUM_CNT      = 6;
   localparam int          FIRST_CNT    = 12;
   // Bit k set: counter FIRST_CNT+k is fed by selector b
   localparam logic [5:0]  GRP_B        = 6'h2C;

   // ****************************************************************
   // Selection register fields
   // ****************************************************************
   localparam int          CLASS_LSB    = 25;
   localparam int          CLASS_W      = 7;
   localparam int          MASK_LSB     = 9;
   localparam int          MASK_W       = 16;
   localparam int          SUP_FLAG_BIT = 3;
   localparam int          USR_FLAG_BIT = 2;
   localparam logic [6:0]  CLASS_BRANCH = 7'h06;
   localparam logic [31:0] SEL_WMASK    = 32'hFFFFFE0C;
   localparam logic [31:0] SEL_RESET    = 32'h00000000;
   localparam int          NTP_BIT      = 0;
   localparam int          NTM_BIT      = 1;
   localparam int          TKP_BIT      = 2;
   localparam int          TKM_BIT      = 3;
   localparam logic        PRECISE_OK   = 1'b0;

   // ****************************************************************
   // Configuration register fields
   // ****************************************************************
   localparam int          CFG_EN_BIT   = 12;
   localparam int          CFG_SEL_LSB  = 13;
   localparam int          CFG_SEL_W    = 3;
   localparam logic [2:0]  SRC_RETIRE   = 3'h5;
   localparam logic [31:0] CFG_WMASK    = 32'h0000F000;
   localparam logic [31:0] CFG_RESET    = 32'h00000000;

   // ****************************************************************
   // Counter
   // ****************************************************************
   localparam int          CNT_W        = 40;
   localparam int          CNT_HI_W     = 8;
   localparam logic [39:0] CNT_RESET    = 40'h0000000000;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  idx;
      logic [31:0] wdata;
   } pes_req_s;

   typedef struct packed {
      logic        valid;
      logic        user_mode;
      logic [3:0]  kind;
   } pes_branch_s;

endpackage : pes_pkg

// ### design/pes_counter.sv
// One wrapping event counter with preset writes.
// Assumes increment and writes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pes_counter
(
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               inc_i,
   input  wire logic               wr_lo_i,
   input  wire logic               wr_hi_i,
   input  wire logic [31:0]        wdata_i,
   output logic [pes_pkg::CNT_W-1:0] cnt_o
);
   import pes_pkg::*;

   // ****************************************************************
   // Counter
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_o <= CNT_RESET;
      end
      else if (wr_lo_i)
      begin
         cnt_o <= {cnt_o[CNT_W-1:32], wdata_i};
      end
      else if (wr_hi_i)
      begin
         cnt_o <= {wdata_i[CNT_HI_W-1:0], cnt_o[31:0]};
      end
      else if (inc_i)
      begin
         cnt_o <= cnt_o + 40'h0000000001; // [R8]
      end
   end

endmodule : pes_counter
`default_nettype wire

// ### design/pes_top.sv
// Event selection front end: two retire selectors, six counters.
// Assumes a register port from the core and branch retire info per cycle.
`timescale 1ns/1ps
`default_nettype none
module pes_top
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire pes_pkg::pes_req_s     req_i,
   input  wire pes_pkg::pes_branch_s  br_i,
   output logic                       ack_o,
   output logic [31:0]                rdata_o,
   output logic                       precise_ok_o
);
   import pes_pkg::*;

   logic [31:0]            sel_a_r;
   logic [31:0]            sel_b_r;
   logic [31:0]            cfg_r [NUM_CNT];
   logic [CNT_W-1:0]       cnt_w [NUM_CNT];
   logic [NUM_CNT-1:0]     inc_w;
   logic                   hit_a_w;
   logic                   hit_b_w;
   logic [31:0]            rdata_nxt;

   // ****************************************************************
   // Event match
   // ****************************************************************
   function automatic logic match(input logic [31:0] sel,
                                  input pes_branch_s br);
      logic cls_ok;
      logic sub_ok;
      logic prv_ok;
      cls_ok = (sel[CLASS_LSB +: CLASS_W] == CLASS_BRANCH);   // [R1]
      // Only mask bits 0-3 are defined for this class
      sub_ok = |(sel[MASK_LSB +: 4] & br.kind);  // [R2] [R3] [R4] [R14]
      prv_ok = br.user_mode ? sel[USR_FLAG_BIT]
                            : sel[SUP_FLAG_BIT];  // [R13]
      match  = br.valid & cls_ok & sub_ok & prv_ok; // [R13]
   endfunction : match

   assign hit_a_w = match(sel_a_r, br_i);
   assign hit_b_w = match(sel_b_r, br_i);

   // ****************************************************************
   // Selection registers
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sel_a_r <= SEL_RESET;
         sel_b_r <= SEL_RESET;
      end
      else if (req_i.wr)
      begin
         if (req_i.idx == IDX_SEL_A)
         begin
            sel_a_r <= req_i.wdata & SEL_WMASK; // [R9]
         end
         if (req_i.idx == IDX_SEL_B)
         begin
            sel_b_r <= req_i.wdata & SEL_WMASK; // [R9]
         end
      end
   end

   // ****************************************************************
   // Configuration registers and counters
   // ****************************************************************
   for (genvar k = 0; k < NUM_CNT; k++)
   begin : g_cnt
      localparam logic [7:0] MY_CFG = IDX_CFG0 + 8'(k);
      localparam logic [7:0] MY_LO  = IDX_CNT_LO0 + 8'(k);
      localparam logic [7:0] MY_HI  = IDX_CNT_HI0 + 8'(k);
      logic src_hit;

      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
         begin
            cfg_r[k] <= CFG_RESET; // [R12]
         end
         else if (req_i.wr && req_i.idx == MY_CFG)
         begin
            cfg_r[k] <= req_i.wdata & CFG_WMASK; // [R11] [R10]
         end
      end

      // Selector number, not address, picks the source
      assign src_hit = GRP_B[k] ? hit_b_w : hit_a_w; // [R6]
      assign inc_w[k] = cfg_r[k][CFG_EN_BIT]
                      & (cfg_r[k][CFG_SEL_LSB +: CFG_SEL_W] == SRC_RETIRE)
                      & src_hit; // [R5] [R12]

      pes_counter i_pes_counter
      (
         .clk_i   (clk_i),
         .rst_n_i (rst_n_i),
         .inc_i   (inc_w[k]),
         .wr_lo_i (req_i.wr && req_i.idx == MY_LO),
         .wr_hi_i (req_i.wr && req_i.idx == MY_HI),
         .wdata_i (req_i.wdata),
         .cnt_o   (cnt_w[k])
      );
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      if (req_i.idx == IDX_SEL_A)
      begin
         rdata_nxt = sel_a_r;
      end
      else if (req_i.idx == IDX_SEL_B)
      begin
         rdata_nxt = sel_b_r;
      end
      for (int j = 0; j < NUM_CNT; j++)
      begin
         if (req_i.idx == IDX_CFG0 + 8'(j))
         begin
            rdata_nxt = cfg_r[j];
         end
         if (req_i.idx == IDX_CNT_LO0 + 8'(j))
         begin
            rdata_nxt = cnt_w[j][31:0];
         end
         if (req_i.idx == IDX_CNT_HI0 + 8'(j))
         begin
            rdata_nxt = {24'h000000, cnt_w[j][CNT_W-1:32]};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ack_o   <= 1'b0;
         rdata_o <= 32'h00000000;
      end
      else
      begin
         ack_o   <= req_i.wr | req_i.rd;
         rdata_o <= req_i.rd ? rdata_nxt : 32'h00000000;
      end
   end

   // No precise sampling for this class
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         precise_ok_o <= 1'b0;
      end
      else
      begin
         precise_ok_o <= PRECISE_OK; // [R7]
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_class_mismatch: assert property ( // [R1]
      sel_a_r[CLASS_LSB +: CLASS_W] != CLASS_BRANCH |-> !hit_a_w)
      else $error("hit with wrong class code");

   a_mask_zero_idle: assert property ( // [R14]
      sel_a_r[MASK_LSB +: 4] == 4'h0 |-> !hit_a_w)
      else $error("hit with empty mask");

   a_mask_needs_sub: assert property ( // [R3]
      hit_a_w |-> br_i.valid && |(sel_a_r[MASK_LSB +: 4] & br_i.kind))
      else $error("hit without enabled sub-event");

   a_priv_user_gate: assert property ( // [R13]
      br_i.user_mode && !sel_a_r[USR_FLAG_BIT] |-> !hit_a_w)
      else $error("user event counted without user flag");

   a_enable_gate: assert property ( // [R12]
      !cfg_r[0][CFG_EN_BIT] && !req_i.wr |=> $stable(cnt_w[0]))
      else $error("disabled counter moved");

   a_count_step: assert property ( // [R8]
      inc_w[0] && !req_i.wr |=> cnt_w[0] == $past(cnt_w[0]) + 40'h1)
      else $error("counter did not step by one");

   a_group_b_src: assert property ( // [R6]
      !hit_b_w && !req_i.wr |=> $stable(cnt_w[2]) && $stable(cnt_w[5]))
      else $error("selector b counter moved without b hit");

   a_sel_write: assert property ( // [R9]
      req_i.wr && req_i.idx == IDX_SEL_A
      |=> sel_a_r == ($past(req_i.wdata) & SEL_WMASK))
      else $error("selection write not taken whole");

   a_cfg_write: assert property ( // [R11]
      req_i.wr && req_i.idx == IDX_CFG0
      |=> cfg_r[0][CFG_SEL_LSB +: CFG_SEL_W]
          == $past(req_i.wdata[CFG_SEL_LSB +: CFG_SEL_W]))
      else $error("config write not taken");

   a_src_number: assert property ( // [R5]
      cfg_r[2][CFG_SEL_LSB +: CFG_SEL_W] != SRC_RETIRE |-> !inc_w[2])
      else $error("counter fed with wrong source number");

   a_no_precise: assert property ( // [R7]
      ##1 !precise_ok_o)
      else $error("precise sampling claimed");

   a_ack_pulse: assert property (
      (req_i.wr || req_i.rd) |=> ack_o)
      else $error("request without ack");

   c_count_a: cover property (inc_w[0] ##1 inc_w[0]);
   c_count_b: cover property (inc_w[2]);
   c_wrap: cover property (inc_w[0] && cnt_w[0] == 40'hFFFFFFFFFF);
   c_all_sub: cover property (hit_a_w && br_i.kind == 4'hF);

endmodule : pes_top
`default_nettype wire

// ### verif/perf_event_select_tb_top.sv
// Self-checking testbench for the performance event selector top.
// Assumes pes_pkg and pes_top are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module perf_event_select_tb_top;
   import pes_pkg::*;

   // ****************************************************************
   // Signals and design
   // ****************************************************************
   logic        clk_i;
   logic        rst_n_i;
   pes_req_s    req_i;
   pes_branch_s br_i;
   logic        ack_o;
   logic [31:0] rdata_o;
   logic        precise_ok_o;
   int          errors;
   int          checks_done;
   // Branch class, both privilege flags
   localparam logic [31:0] SEL_ON = {CLASS_BRANCH, 25'h0} | 32'h0000000C;
   localparam logic [31:0] MASK_ALL = 32'h0000001E;
   // Source 5 and enable
   localparam logic [31:0] CFG_ON = 32'h0000B000;

   pes_top i_pes_top (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .req_i        (req_i),
      .br_i         (br_i),
      .ack_o        (ack_o),
      .rdata_o      (rdata_o),
      .precise_ok_o (precise_ok_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Compare and bus tasks
   // ****************************************************************
   task automatic cmp_val(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, idx: a, wdata: d};
      @(posedge clk_i);
      req_i <= '0;
      #1 cmp_bit(ack_o, 1'b1);
   endtask : reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, idx: a, wdata: 32'h00000000};
      @(posedge clk_i);
      req_i <= '0;
      #1 cmp_bit(ack_o, 1'b1);
      cmp_val({8'h00, rdata_o}, {8'h00, exp});
   endtask : rd_chk

   task automatic cnt_chk(input logic [7:0] k, input logic [39:0] exp);
      rd_chk(IDX_CNT_LO0 + k, exp[31:0]);
      rd_chk(IDX_CNT_HI0 + k, {24'h000000, exp[39:32]});
   endtask : cnt_chk

   task automatic ev(input logic u, input logic [3:0] kd, input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         br_i <= '{valid: 1'b1, user_mode: u, kind: kd};
      end
      @(posedge clk_i);
      br_i <= '0;
   endtask : ev

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      rd_chk(IDX_SEL_A, SEL_RESET);
      cmp_bit(precise_ok_o, PRECISE_OK);
      rd_chk(IDX_CFG0, CFG_RESET);
      rd_chk(8'h7F, 32'h00000000);
      cnt_chk(8'h00, CNT_RESET);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fields;
      reg_wr(IDX_SEL_A, 32'hFE001FFF);
      rd_chk(IDX_SEL_A, 32'hFE001FFF & SEL_WMASK);
      reg_wr(IDX_CFG0, 32'hFFFFFFFF);
      rd_chk(IDX_CFG0, CFG_WMASK);
      $display("test fields done");
   endtask : t_fields

   task automatic t_kinds;
      reg_wr(IDX_CFG0, CFG_ON);
      for (int i = 0; i < 4; i++)
      begin
         reg_wr(IDX_SEL_A, SEL_ON | (32'h00000200 << i));
         reg_wr(IDX_CNT_LO0, 32'h00000000);
         ev(1'b0, 4'hF ^ (4'h1 << i), 2);
         ev(1'b0, 4'h1 << i, 3);
         cnt_chk(8'h00, 40'h0000000003);
      end
      $display("test kinds done");
   endtask : t_kinds

   task automatic t_priv;
      reg_wr(IDX_SEL_A, {CLASS_BRANCH, 25'h0} | (MASK_ALL << 8) | 32'h4);
      reg_wr(IDX_CNT_LO0, 32'h00000000);
      ev(1'b0, 4'hF, 4);
      ev(1'b1, 4'hF, 2);
      cnt_chk(8'h00, 40'h0000000002);
      reg_wr(IDX_SEL_A, SEL_ON);
      ev(1'b1, 4'hF, 3);
      cnt_chk(8'h00, 40'h0000000002);
      reg_wr(IDX_SEL_A, {CLASS_BRANCH, 25'h0} | (MASK_ALL << 8) | 32'h8);
      ev(1'b1, 4'hF, 2);
      ev(1'b0, 4'hF, 1);
      cnt_chk(8'h00, 40'h0000000003);
      reg_wr(IDX_SEL_A, 32'h0E00000C | (MASK_ALL << 8));
      ev(1'b0, 4'hF, 2);
      cnt_chk(8'h00, 40'h0000000003);
      $display("test privilege done");
   endtask : t_priv

   task automatic t_route;
      reg_wr(IDX_SEL_B, SEL_ON | (MASK_ALL << 8));
      reg_wr(IDX_CFG0 + 8'h02, 32'h0000A000);
      ev(1'b0, 4'hF, 2);
      cnt_chk(8'h02, 40'h0000000000);
      reg_wr(IDX_CFG0 + 8'h02, 32'h0000D000);
      ev(1'b0, 4'hF, 2);
      cnt_chk(8'h02, 40'h0000000000);
      reg_wr(IDX_CFG0 + 8'h02, CFG_ON);
      ev(1'b0, 4'hF, 3);
      cnt_chk(8'h02, 40'h0000000003);
      cnt_chk(8'h00, 40'h0000000003);
      $display("test routing done");
   endtask : t_route

   task automatic t_wrap;
      reg_wr(IDX_SEL_A, SEL_ON | (MASK_ALL << 8));
      reg_wr(IDX_CNT_LO0, 32'hFFFFFFFF);
      reg_wr(IDX_CNT_HI0, 32'h000000FF);
      cnt_chk(8'h00, 40'hFFFFFFFFFF);
      ev(1'b0, 4'h1, 1);
      cnt_chk(8'h00, 40'h0000000000);
      $display("test wrap done");
   endtask : t_wrap

   // ****************************************************************
   // Run control
   // ****************************************************************
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      errors = 0;
      checks_done = 0;
      rst_n_i = 1'b0;
      req_i = '0;
      br_i = '0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset;
      t_fields;
      t_kinds;
      t_priv;
      t_route;
      t_wrap;
      end_of_test;
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      errors++;
      end_of_test;
   end

endmodule : perf_event_select_tb_top
`default_nettype wire
